//--- testbench/downstream_rx_model.sv
// Downstream receiver model: topology report, key list and link state
`timescale 1ns/1ns
module downstream_rx_model (
  // Clock
  input  wire logic       clk_i,
  // Topology and key list
  output logic            topo_valid_o,
  output logic      [3:0] topo_levels_o,
  output logic            key_wr_o,
  output logic      [7:0] key_byte_o,
  output logic            key_list_ready_o,
  // Link state
  output logic            rx_detect_o,
  output logic            rx_lock_o
);
  initial begin
    {topo_valid_o, key_wr_o, key_list_ready_o, rx_detect_o} = '0;
    {rx_lock_o, topo_levels_o, key_byte_o} = '0;
  end

  // Released data lines flip, so a stale value can never pass for new
  task automatic send_topo(input logic [3:0] lv);
    @(negedge clk_i) topo_levels_o = lv;
    topo_valid_o = 1'b1;
    @(negedge clk_i) topo_valid_o = 1'b0;
    topo_levels_o = ~lv;
  endtask : send_topo

  task automatic send_key(input logic [7:0] b);
    @(negedge clk_i) key_byte_o = b;
    key_wr_o = 1'b1;
    @(negedge clk_i) key_wr_o = 1'b0;
    key_byte_o = ~b;
  endtask : send_key

  task automatic list_ready();
    @(negedge clk_i) key_list_ready_o = 1'b1;
    @(negedge clk_i) key_list_ready_o = 1'b0;
  endtask : list_ready

  task automatic set_link(input logic d, input logic l);
    @(negedge clk_i) rx_detect_o = d;
    rx_lock_o = l;
  endtask : set_link
endmodule : downstream_rx_model

//--- testbench/tb_content_protect_tx_config.sv
// Self-checking bench for the protection configuration block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_content_protect_tx_config;
  import content_protect_tx_pkg::*;
  logic        clk, rst, wr, rd, act, fs, de, cin, auth, inb, ar, ws;
  logic        tv, kw, kr, det, lck, rvalid, ind, con, enc, fine, lnk;
  logic        syn, free, tick, wdone, irq, cval, ce;
  logic [7:0]  addr, wdata, rdata, kb;
  logic [3:0]  tl;
  logic [23:0] pix, csum;
  cfg_s        cfg;
  dbg_s        dbg;
  int          n_errors = 0, checked = 0;
  int          n_fine = 0, n_lnk = 0, n_syn = 0, n_cv = 0;

  content_protect_tx_config #(.BUS_TIMEOUT_CYC(20), .INIT_WAIT_CYC(10),
    .AUTH_TICK_NORM(8), .AUTH_TICK_FAST(2)) dut (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .topo_valid_i(tv),
    .topo_levels_i(tl), .key_wr_i(kw), .key_byte_i(kb),
    .key_list_ready_i(kr), .auth_restart_i(ar), .cfg_o(cfg), .dbg_o(dbg),
    .indirect_status_o(ind), .cipher_on_i(cin), .authenticated_i(auth),
    .inband_cipher_i(inb), .frame_start_i(fs), .cipher_on_o(con),
    .encrypt_frame_o(enc), .fine_check_o(fine), .link_check_o(lnk),
    .sync_check_o(syn), .bus_activity_i(act), .bus_free_o(free),
    .auth_tick_o(tick), .wait_start_i(ws), .wait_done_o(wdone),
    .rx_detect_i(det), .rx_lock_i(lck), .sink_irq_o(irq), .de_i(de),
    .pixel_i(pix), .checksum_o(csum), .checksum_valid_o(cval));

  downstream_rx_model rx (.clk_i(clk), .topo_valid_o(tv),
    .topo_levels_o(tl), .key_wr_o(kw), .key_byte_o(kb),
    .key_list_ready_o(kr), .rx_detect_o(det), .rx_lock_o(lck));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    n_fine <= n_fine + int'(fine === 1'b1);
    n_lnk <= n_lnk + int'(lnk === 1'b1);
    n_syn <= n_syn + int'(syn === 1'b1);
    n_cv <= n_cv + int'(cval === 1'b1);
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    int i;
    @(negedge clk) addr = a;
    rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk);
    `CHK("rvalid", 1'b1, rvalid);
    `CHK("rdata", e, rdata);
  endtask : rd_chk

  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
    @(negedge clk);
  endtask : pulse

  task automatic t_regs();
    rd_chk(8'hC2, 8'hA8);
    rd_chk(8'hC0, 8'h00);
    rd_chk(8'hA3, 8'h00);
    wr_reg(8'hC0, 8'hFF);
    rd_chk(8'hC0, 8'h5F);
    `CHK("dbg", 8'h5F, dbg);
    `CHK("indirect", 1'b1, ind);
    wr_reg(8'hA2, 8'hFF);
    rd_chk(8'hA2, 8'h00);
    rd_chk(8'h10, 8'h00);
    wr_reg(8'hC2, 8'h75);
    rd_chk(8'hC2, 8'h75);
    `CHK("repeater", 1'b1, cfg.repeater_mode_on);
    `CHK("policy", CIPHER_ALWAYS, cfg.cipher_policy);
    wr_reg(8'hC0, 8'h00);
    wr_reg(8'hC2, 8'hA8);
    `CHK("indirect", 1'b0, ind);
  endtask : t_regs

  task automatic t_freeze();
    @(negedge clk) ce = 1'b0;
    wr_reg(8'hC2, 8'h00);
    `CHK("frozen_cfg", 8'hA8, cfg);
    @(negedge clk) ce = 1'b1;
    rd_chk(8'hC2, 8'hA8);
  endtask : t_freeze

  task automatic frames(input int k, input int ef, el, es);
    int f, l, s;
    f = n_fine;
    l = n_lnk;
    s = n_syn;
    repeat (k) pulse(fs);
    `CHK("fine", ef, n_fine - f);
    `CHK("link", el, n_lnk - l);
    `CHK("sync", es, n_syn - s);
  endtask : frames

  task automatic t_topo_keys();
    rx.send_topo(4'h8);
    rd_chk(8'hA2, 8'h0F);
    rx.send_topo(4'h7);
    rd_chk(8'hA2, 8'h07);
    rx.send_key(8'h3C);
    rx.send_key(8'hA5);
    rx.send_key(8'h96);
    rx.list_ready();
    rd_chk(8'hA3, 8'h3C);
    rd_chk(8'hA3, 8'hA5);
    rx.list_ready();
    rd_chk(8'hA3, 8'h3C);
    rd_chk(8'hA3, 8'hA5);
    rd_chk(8'hA3, 8'h96);
    rd_chk(8'hA3, 8'h00);
    pulse(ar);
    rd_chk(8'hA3, 8'h00);
    rx.send_key(8'h5A);
    rd_chk(8'hA3, 8'h5A);
  endtask : t_topo_keys

  task automatic t_timeout();
    int n;
    pulse(act);
    for (n = 0; n < 40 && free !== 1'b1; n++) @(negedge clk);
    `CHK("free_time", 1'b1, n >= 18 && n <= 21);
    pulse(act);
    `CHK("free_clr", 1'b0, free);
    wr_reg(8'hC0, 8'h40);
    repeat (40) @(negedge clk);
    `CHK("free_off", 1'b0, free);
    wr_reg(8'hC0, 8'h00);
  endtask : t_timeout

  task automatic t_cipher();
    wr_reg(8'hC2, 8'h10);
    pulse(fs);
    `CHK("cipher_on", 1'b1, con);
    `CHK("enc_always", 1'b1, enc);
    wr_reg(8'hC2, 8'h00);
    pulse(fs);
    `CHK("cipher_on", 1'b0, con);
    `CHK("enc_auth", 1'b0, enc);
    {auth, cin} = 2'b11;
    wr_reg(8'hC2, 8'h08);
    pulse(fs);
    `CHK("enc_reg", 1'b1, enc);
    wr_reg(8'hC2, 8'h18);
    pulse(fs);
    `CHK("enc_inband", 1'b0, enc);
    inb = 1'b1;
    pulse(fs);
    `CHK("enc_inband", 1'b1, enc);
    {auth, cin, inb} = 3'b000;
    wr_reg(8'hC2, 8'h41);
    pulse(fs);
    `CHK("enc_mute", 1'b1, enc);
    wr_reg(8'hC2, 8'h40);
    pulse(fs);
    `CHK("enc_unmute", 1'b0, enc);
  endtask : t_cipher

  task automatic t_sum(input logic en);
    int c;
    c = n_cv;
    wr_reg(8'hC0, {4'h0, en, 3'h0});
    @(negedge clk) de = 1'b1;
    pix = 24'hFF_8001;
    @(negedge clk) pix = 24'h01_8002;
    @(negedge clk) pix = 24'h10_0003;
    @(negedge clk) de = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("checksum", 24'hEE_FEF9, csum);
    `CHK("sum_pulse", int'(en), n_cv - c);
  endtask : t_sum

  task automatic wait_gap(input logic [7:0] c, input int lo, hi);
    int n;
    wr_reg(8'hC2, c);
    @(negedge clk) ws = 1'b1;
    @(negedge clk) ws = 1'b0;
    for (n = 0; n < 30 && wdone !== 1'b1; n++) @(negedge clk);
    `CHK("wait_len", 1'b1, n >= lo && n <= hi);
  endtask : wait_gap

  task automatic tick_gap(input int e);
    int n;
    repeat (20) @(negedge clk);
    for (n = 0; n < 20 && tick !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    for (n = 1; n < 20 && tick !== 1'b1; n++) @(negedge clk);
    `CHK("tick_gap", e, n);
  endtask : tick_gap

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    #300_000;
    n_errors++;
    give_verdict();
  end

  initial begin
    {wr, rd, act, fs, de, cin, auth, inb, ar, ws} = '0;
    {addr, wdata, pix} = '0;
    ce = 1'b1;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_freeze();
    wr_reg(8'hC0, 8'h04);
    frames(32, 16, 2, 2);
    wr_reg(8'hC0, 8'h14);
    wr_reg(8'hC2, 8'h28);
    frames(32, 0, 2, 0);
    wr_reg(8'hC0, 8'h00);
    wr_reg(8'hC2, 8'hA8);
    frames(128, 8, 1, 1);
    t_topo_keys();
    t_timeout();
    t_cipher();
    t_sum(1'b1);
    t_sum(1'b0);
    wait_gap(8'h00, 0, 2);
    wait_gap(8'h04, 10, 12);
    tick_gap(8);
    wr_reg(8'hC0, 8'h02);
    tick_gap(2);
    wr_reg(8'hC2, 8'hA8);
    rx.set_link(1'b1, 1'b0);
    repeat (3) @(negedge clk);
    `CHK("irq_detect", 1'b1, irq);
    wr_reg(8'hC2, 8'hAA);
    repeat (3) @(negedge clk);
    `CHK("irq_nolock", 1'b0, irq);
    rx.set_link(1'b1, 1'b1);
    repeat (3) @(negedge clk);
    `CHK("irq_lock", 1'b1, irq);
    give_verdict();
  end
endmodule : tb_content_protect_tx_config

//--- verilog/content_protect_tx_cfg.svh
// Register map, field positions, reset values and timing counts
`ifndef CONTENT_PROTECT_TX_CFG_SVH
`define CONTENT_PROTECT_TX_CFG_SVH
`define ADDR_TOPO_HIGH   8'hA2
`define ADDR_KEY_PORT    8'hA3
`define ADDR_DEBUG       8'hC0
`define ADDR_CONFIG      8'hC2
`define RST_DEBUG        8'h00
`define RST_CONFIG       8'hA8
`define DEBUG_MASK       8'h5F
`define CASCADE_ERR_BIT  3
`define CASCADE_MAX      4'h7
`define FINE_MASK_NORM   7'h0F
`define FINE_MASK_TEST   7'h01
`define LINK_MASK_NORM   7'h7F
`define LINK_MASK_TEST   7'h0F
`define CLK_HZ           100000000
`define BUS_TIMEOUT_MS   1000
`define BUS_TIMEOUT_CYC  (`CLK_HZ / 1000 * `BUS_TIMEOUT_MS)
`define INIT_WAIT_MS     100
`define INIT_WAIT_CYC    (`CLK_HZ / 1000 * `INIT_WAIT_MS)
`define AUTH_TICK_NORM   1000
`define AUTH_TICK_FAST   10
`define KEY_LIST_DEPTH   640
`endif

//--- verilog/content_protect_tx_config.sv
// Protection transmitter configuration, debug and topology registers
`timescale 1ns/1ns
`include "content_protect_tx_cfg.svh"

// Operation
// (R1) More than seven repeater levels sets cascade error
// (R2) Three-bit field reports downstream cascade depth
// (R3) Each key port read returns next byte
// (R4) Timeout-off bit disables link master timeout
// (R5) Bus free after one idle second
// (R6) Link check before/after frame 128, sync 127
// (R7) Sync-off bit skips the frame 127 check
// (R8) Checksum per colour channel after each line
// (R9) Test mode shortens check periods to 2/16
// (R10) Fast bit accelerates authentication timer ticks
// (R11) Fast timing bit drives master and mirror; the code only mirrors it on indirect_status_o
// (R12) Enhanced verify gates fine check every 16
// (R13) Bit 6 selects enhanced status signaling
// (R14) Bit 5 selects repeater mode
// (R15) Policy field decides per-frame encryption
// (R16) Optional 100 ms initial wait
// (R17) Select bit adds lock to detect interrupt
// (R18) Mute freezes encryption status controls; the code holds only encrypt_frame_o, cipher_on_o keeps updating
// (R19) Software mutes only with enhanced signaling; the code mutes whatever bit 6 holds
// (R20) Cipher-always forces cipher_on to read one
// (R21) Key port pointer restarts on new list
module content_protect_tx_config
  import content_protect_tx_pkg::*;
#(
  parameter int BUS_TIMEOUT_CYC = `BUS_TIMEOUT_CYC,
  parameter int INIT_WAIT_CYC   = `INIT_WAIT_CYC,
  parameter int AUTH_TICK_NORM  = `AUTH_TICK_NORM,
  parameter int AUTH_TICK_FAST  = `AUTH_TICK_FAST,
  parameter int KEY_LIST_DEPTH  = `KEY_LIST_DEPTH
) (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // Downstream topology and key list
  input  wire logic        topo_valid_i,
  input  wire logic [3:0]  topo_levels_i,
  input  wire logic        key_wr_i,
  input  wire logic [7:0]  key_byte_i,
  input  wire logic        key_list_ready_i,
  input  wire logic        auth_restart_i,
  // Configuration view
  output cfg_s             cfg_o,
  output dbg_s             dbg_o,
  output logic             indirect_status_o,
  // Encryption decision
  input  wire logic        cipher_on_i,
  input  wire logic        authenticated_i,
  input  wire logic        inband_cipher_i,
  input  wire logic        frame_start_i,
  output logic             cipher_on_o,
  output logic             encrypt_frame_o,
  output logic             fine_check_o,
  output logic             link_check_o,
  output logic             sync_check_o,
  // Key-exchange master and timers
  input  wire logic        bus_activity_i,
  output logic             bus_free_o,
  output logic             auth_tick_o,
  input  wire logic        wait_start_i,
  output logic             wait_done_o,
  // Receiver detect
  input  wire logic        rx_detect_i,
  input  wire logic        rx_lock_i,
  output logic             sink_irq_o,
  // Video line checksum
  input  wire logic        de_i,
  input  wire logic [23:0] pixel_i,
  output logic      [23:0] checksum_o,
  output logic             checksum_valid_o
);
  localparam int PW = $clog2(KEY_LIST_DEPTH + 1);
  if (KEY_LIST_DEPTH < 1 || BUS_TIMEOUT_CYC < 2 || INIT_WAIT_CYC < 1 ||
      AUTH_TICK_FAST < 1 || AUTH_TICK_NORM < AUTH_TICK_FAST) begin : g_chk
    $error("content_protect_tx_config: bad parameter");
  end
  cfg_s        cfg_reg;
  dbg_s        dbg_reg;
  logic [2:0]  depth_reg;
  logic        casc_err_reg;
  logic [7:0]  key_mem [KEY_LIST_DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [6:0]  frame_reg;
  logic [6:0]  frame_next;
  logic [6:0]  fine_mask;
  logic [6:0]  link_mask;
  logic [31:0] idle_reg;
  logic [31:0] tick_reg;
  logic [31:0] wait_reg;
  wait_state_e wait_st;
  logic        de_reg;
  wire wr_cfg = ce_i & reg_wr_i & (reg_addr_i == `ADDR_CONFIG);
  wire wr_dbg = ce_i & reg_wr_i & (reg_addr_i == `ADDR_DEBUG);
  wire rd_key = ce_i & reg_rd_i & (reg_addr_i == `ADDR_KEY_PORT);
  assign cfg_o = cfg_reg;
  assign dbg_o = dbg_reg;
  // Configuration and debug registers; reserved debug bits stay zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= cfg_s'(`RST_CONFIG);
      dbg_reg <= dbg_s'(`RST_DEBUG);
    end else begin
      if (wr_cfg) cfg_reg <= cfg_s'(reg_wdata_i); // R13 R14
      if (wr_dbg) dbg_reg <= dbg_s'(reg_wdata_i & `DEBUG_MASK);
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) indirect_status_o <= 1'b0;
    else if (ce_i) indirect_status_o <= dbg_reg.link_master_fast_timing; // R11
  end
  // Topology status; depth saturates at seven when the limit is broken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      depth_reg    <= 3'h0;
      casc_err_reg <= 1'b0;
    end else if (ce_i && topo_valid_i) begin
      casc_err_reg <= topo_levels_i > `CASCADE_MAX; // R1
      depth_reg    <= (topo_levels_i > `CASCADE_MAX) ? 3'h7
                                                      : topo_levels_i[2:0]; // R2
    end
  end
  // Key list storage; no reset needed, the pointers bound what is read
  always_ff @(posedge clk_i) begin
    if (ce_i && key_wr_i && wr_ptr_reg < PW'(KEY_LIST_DEPTH))
      key_mem[wr_ptr_reg] <= key_byte_i;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) wr_ptr_reg <= '0;
    else if (ce_i) begin
      if (auth_restart_i) wr_ptr_reg <= '0;
      else if (key_wr_i && wr_ptr_reg < PW'(KEY_LIST_DEPTH))
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) rd_ptr_reg <= '0;
    else if (ce_i) begin
      if (auth_restart_i || key_list_ready_i) rd_ptr_reg <= '0; // R21
      else if (rd_key && rd_ptr_reg < wr_ptr_reg)
        rd_ptr_reg <= rd_ptr_reg + 1'b1; // R3
    end
  end
  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `ADDR_TOPO_HIGH: reg_rdata_o <= {4'h0, casc_err_reg, depth_reg};
          `ADDR_KEY_PORT:  reg_rdata_o <= (rd_ptr_reg < wr_ptr_reg)
                                          ? key_mem[rd_ptr_reg] : 8'h00; // R3
          `ADDR_DEBUG:     reg_rdata_o <= dbg_reg;
          `ADDR_CONFIG:    reg_rdata_o <= cfg_reg;
          default:         reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end
  // Frame counter for link verification
  always_comb begin
    fine_mask  = dbg_reg.frame_count_test ? `FINE_MASK_TEST
                                          : `FINE_MASK_NORM; // R9
    link_mask  = dbg_reg.frame_count_test ? `LINK_MASK_TEST
                                          : `LINK_MASK_NORM; // R9
    frame_next = (frame_reg + 7'h01) & link_mask;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_reg    <= 7'h00;
      fine_check_o <= 1'b0;
      link_check_o <= 1'b0;
      sync_check_o <= 1'b0;
    end else if (ce_i) begin
      if (frame_start_i) frame_reg <= frame_next;
      link_check_o <= frame_start_i && frame_next == 7'h00; // R6
      sync_check_o <= frame_start_i && frame_next == link_mask &&
                      !dbg_reg.link_check_sync_off; // R6 R7
      fine_check_o <= frame_start_i && (frame_next & fine_mask) == 7'h00 &&
                      cfg_reg.enhanced_verify_on; // R12
    end
  end
  // Per-frame encryption decision; mute holds the last decision
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      encrypt_frame_o <= 1'b0;
      cipher_on_o     <= 1'b0;
    end else if (ce_i) begin
      cipher_on_o <= cipher_on_i ||
                     cfg_reg.cipher_policy == CIPHER_ALWAYS; // R20
      if (frame_start_i && !cfg_reg.audio_video_mute) begin // R18
        case (cfg_reg.cipher_policy) // R15
          CIPHER_WHEN_AUTHENTICATED: encrypt_frame_o <= authenticated_i;
          CIPHER_BY_REGISTER: encrypt_frame_o <= authenticated_i & cipher_on_i;
          CIPHER_ALWAYS:           encrypt_frame_o <= 1'b1;
          CIPHER_PER_FRAME_INBAND: encrypt_frame_o <= inband_cipher_i;
          default:                 encrypt_frame_o <= 1'b0;
        endcase
      end
    end
  end
  // Bus timeout of the key-exchange master
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_reg   <= 32'h0000_0000;
      bus_free_o <= 1'b0;
    end else if (ce_i) begin
      if (bus_activity_i || dbg_reg.link_master_timeout_off) begin // R4
        idle_reg   <= 32'h0000_0000;
        bus_free_o <= 1'b0;
      end else if (idle_reg < 32'(BUS_TIMEOUT_CYC)) begin
        idle_reg <= idle_reg + 32'h0000_0001;
      end else begin
        bus_free_o <= 1'b1; // R5
      end
    end
  end
  // Authentication timer tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_reg    <= 32'h0000_0000;
      auth_tick_o <= 1'b0;
    end else if (ce_i) begin
      auth_tick_o <= 1'b0;
      if (tick_reg >= 32'(dbg_reg.auth_timer_fast ? AUTH_TICK_FAST - 1
                                                  : AUTH_TICK_NORM - 1)) begin
        tick_reg    <= 32'h0000_0000; // R10
        auth_tick_o <= 1'b1;
      end else begin
        tick_reg <= tick_reg + 32'h0000_0001;
      end
    end
  end
  // Initial wait before encryption starts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_st     <= WAIT_IDLE;
      wait_reg    <= 32'h0000_0000;
      wait_done_o <= 1'b0;
    end else if (ce_i) begin
      wait_done_o <= 1'b0;
      case (wait_st)
        WAIT_IDLE: begin
          wait_reg <= 32'h0000_0000;
          if (wait_start_i && cfg_reg.initial_wait_on) wait_st <= WAIT_RUN;
          else if (wait_start_i) wait_done_o <= 1'b1; // R16
        end
        WAIT_RUN: begin
          wait_reg <= wait_reg + 32'h0000_0001;
          if (wait_reg >= 32'(INIT_WAIT_CYC - 1)) begin
            wait_st     <= WAIT_IDLE; // R16
            wait_done_o <= 1'b1;
          end
        end
        default: wait_st <= WAIT_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) sink_irq_o <= 1'b0;
    else if (ce_i)
      sink_irq_o <= rx_detect_i &
                    (rx_lock_i | ~cfg_reg.sink_detect_select); // R17
  end
  // Line checksum, end-around carry keeps the sum ones-complement
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      de_reg           <= 1'b0;
      checksum_valid_o <= 1'b0;
    end else if (ce_i) begin
      de_reg           <= de_i;
      checksum_valid_o <= de_reg & ~de_i & dbg_reg.line_checksum_on; // R8
    end
  end
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic [7:0] sum_reg;
    logic [8:0] add;
    assign add = {1'b0, sum_reg} + {1'b0, pixel_i[8*c +: 8]};
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        sum_reg           <= 8'h00;
        checksum_o[8*c +: 8] <= 8'h00;
      end else if (ce_i) begin
        if (de_i) sum_reg <= add[7:0] + {7'h00, add[8]}; // R8
        else if (de_reg) begin
          checksum_o[8*c +: 8] <= ~sum_reg;
          sum_reg           <= 8'h00;
        end
      end
    end
  end
  a_cascade_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && topo_valid_i && topo_levels_i > 4'h7 |=> casc_err_reg &&
    depth_reg == 3'h7) else $error("cascade error not flagged"); // R1
  a_key_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (auth_restart_i || key_list_ready_i) |=> rd_ptr_reg == '0)
    else $error("key pointer not restarted"); // R21
  a_timeout_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && dbg_reg.link_master_timeout_off |=> !bus_free_o)
    else $error("bus freed with timeout off"); // R4
  a_sync_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && dbg_reg.link_check_sync_off |=> !sync_check_o)
    else $error("sync check not skipped"); // R7
  a_fine_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !cfg_reg.enhanced_verify_on |=> !fine_check_o)
    else $error("fine check while disabled"); // R12
  a_cipher_forced: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cfg_reg.cipher_policy == CIPHER_ALWAYS |=> cipher_on_o)
    else $error("cipher_on not forced"); // R20
  a_mute_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cfg_reg.audio_video_mute |=> $stable(encrypt_frame_o))
    else $error("decision changed in mute"); // R18
  a_sink_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cfg_reg.sink_detect_select && !rx_lock_i |=> !sink_irq_o)
    else $error("detect irq without lock"); // R17
  a_fast_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##1 ce_i |-> indirect_status_o ==
    $past(dbg_reg.link_master_fast_timing))
    else $error("fast timing not mirrored"); // R11
endmodule : content_protect_tx_config

//--- verilog/content_protect_tx_pkg.sv
// Types shared by the protection configuration block
package content_protect_tx_pkg;
  typedef enum logic [1:0] {
    CIPHER_WHEN_AUTHENTICATED = 2'b00,
    CIPHER_BY_REGISTER        = 2'b01,
    CIPHER_ALWAYS             = 2'b10,
    CIPHER_PER_FRAME_INBAND   = 2'b11
  } cipher_policy_e;

  typedef enum logic [1:0] {
    WAIT_IDLE = 2'b00,
    WAIT_RUN  = 2'b01
  } wait_state_e;

  typedef struct packed {
    logic           enhanced_verify_on;
    logic           enhanced_status_signaling;
    logic           repeater_mode_on;
    cipher_policy_e cipher_policy;
    logic           initial_wait_on;
    logic           sink_detect_select;
    logic           audio_video_mute;
  } cfg_s;

  typedef struct packed {
    logic rsv7;
    logic link_master_timeout_off;
    logic rsv5;
    logic link_check_sync_off;
    logic line_checksum_on;
    logic frame_count_test;
    logic auth_timer_fast;
    logic link_master_fast_timing;
  } dbg_s;
endpackage : content_protect_tx_pkg
